// [shared/oswfs_regs.vh]
// constants for the octal switch fault and status logic
`ifndef OSWFS_REGS_VH
`define OSWFS_REGS_VH
`define OSWFS_WIDTH 8
`define OSWFS_ALL_OFF 8'hFF
`define OSWFS_CLK_MHZ 50
`define OSWFS_OPEN_DELAY_US 50
`define OSWFS_SHORT_DELAY_US 70
`define OSWFS_CNT_W 14
`endif

// [rtl/oswfs_delay_timer.v]
// restartable fault delay timer, started on each chip-select rise
`timescale 1ns/1ps
module oswfs_delay_timer #(
  parameter CNT_W = 14,
  parameter [CNT_W-1:0] CYCLES = 2500
)
(
  input wire clk_sys,
  input wire reset_n,
  input wire start,
  output reg expired
);
  reg [CNT_W-1:0] count;
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= {CNT_W{1'b0}};
      expired <= 1'b0;
    end
    else if (start)
    begin
      // restart on every rise, even mid-count
      count <= CYCLES;
      expired <= 1'b0;
    end
    else if (count != {CNT_W{1'b0}})
    begin
      count <= count - {{(CNT_W-1){1'b0}}, 1'b1};
      expired <= (count == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end
endmodule

// [rtl/oswfs_channel.v]
// per-output switch state and fault handling for one channel
`timescale 1ns/1ps
module oswfs_channel
(
  input wire clk_sys,
  input wire reset_n,
  input wire loadCmd,
  input wire cmdOff,
  input wire overTemp,
  input wire overVoltage,
  input wire drainThreshold,
  input wire shortProtectDisable,
  input wire openWindow,
  input wire shortWindow,
  output wire switchOn,
  output wire statusBit
);
  reg commandedOn;
  reg latchedOff;
  wire shortSeen;
  wire openSeen;
  // drain above threshold while on means short; below while off means open
  assign shortSeen = commandedOn & drainThreshold;
  assign openSeen = ~commandedOn & ~drainThreshold & openWindow;
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      commandedOn <= 1'b0;
      latchedOff <= 1'b0;
    end
    else if (overVoltage)
    begin
      commandedOn <= 1'b0;
      latchedOff <= 1'b0;
    end
    else if (loadCmd)
    begin
      commandedOn <= ~cmdOff;
      // heat in the same cycle as the command still latches: set wins
      latchedOff <= overTemp & ~cmdOff;
    end
    else if (overTemp & commandedOn)
      latchedOff <= 1'b1;
    else if (shortSeen & ~shortProtectDisable & shortWindow)
      latchedOff <= 1'b1;
  end
  // thermal cutoff acts combinationally, independent of the serial logic
  assign switchOn = commandedOn & ~latchedOff & ~overTemp & ~overVoltage;
  // off or shorted reads one; open load reads zero, as does on and clean
  assign statusBit = ~switchOn | shortSeen | openSeen ? ~openSeen : 1'b0;
endmodule

// [rtl/oswfs_fault_logic.v]
// octal switch fault and status logic, top level
// Contract
// - status returned reflects previous command word
// - command zero means on, one off
// - per-output faults, global over-voltage
// - thermal shutdown affects only that output
// - thermal-off output reports off status
// - recovery needs a new on command
// - over-voltage turns all off until reprogrammed
// - status after over-voltage is all ones
// - open load only checked when off
// - one comparator: open when off, short when on
// - chip-select rise starts open-load delay timer
// - open load is not latched
// - thermal limit latches only that output
// - over-current trips short fault flag
// - protect-disable selects shutdown or current limit
// - chip-select fall loads status, enables output
// - chip-select rise applies command to switches
// - status one when off, zero when on
// - reset clears shifter, switches off
`timescale 1ns/1ps
`include "oswfs_regs.vh"
module oswfs_fault_logic #(
  parameter WIDTH = `OSWFS_WIDTH,
  parameter OPEN_DELAY_US = `OSWFS_OPEN_DELAY_US,
  parameter SHORT_DELAY_US = `OSWFS_SHORT_DELAY_US
)
(
  input wire clk_sys,
  input wire reset_n,
  input wire chipSelect_n,
  input wire shiftStrobe,
  input wire serialIn,
  input wire [WIDTH-1:0] overTemp,
  input wire loadSupplyOverVoltage,
  input wire [WIDTH-1:0] drainThreshold,
  input wire shortProtectDisable,
  output wire [WIDTH-1:0] switchOn,
  output reg serialOut,
  output reg serialOutEnable,
  output reg [WIDTH-1:0] commandWord
);
  // products kept wide, then cut to the counter width on purpose
  localparam [31:0] OPEN_PRODUCT = OPEN_DELAY_US * `OSWFS_CLK_MHZ;
  localparam [31:0] SHORT_PRODUCT = SHORT_DELAY_US * `OSWFS_CLK_MHZ;
  localparam [`OSWFS_CNT_W-1:0] OPEN_CYCLES = OPEN_PRODUCT[`OSWFS_CNT_W-1:0];
  localparam [`OSWFS_CNT_W-1:0] SHORT_CYCLES = SHORT_PRODUCT[`OSWFS_CNT_W-1:0];
  reg csPrev;
  reg ovSticky;
  reg [WIDTH-1:0] shifter;
  wire csFall;
  wire csRise;
  wire openWindow;
  wire shortWindow;
  wire [WIDTH-1:0] statusBits;
  assign csFall = csPrev & ~chipSelect_n;
  assign csRise = ~csPrev & chipSelect_n;
  oswfs_delay_timer #(.CNT_W(`OSWFS_CNT_W), .CYCLES(OPEN_CYCLES)) openTimer
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(csRise),
    .expired(openWindow)
  );
  oswfs_delay_timer #(.CNT_W(`OSWFS_CNT_W), .CYCLES(SHORT_CYCLES)) shortTimer
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(csRise),
    .expired(shortWindow)
  );
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gChan
      oswfs_channel chan
      (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .loadCmd(csRise & ~loadSupplyOverVoltage),
        .cmdOff(shifter[i]),
        .overTemp(overTemp[i]),
        .overVoltage(loadSupplyOverVoltage),
        .drainThreshold(drainThreshold[i]),
        .shortProtectDisable(shortProtectDisable),
        .openWindow(openWindow),
        .shortWindow(shortWindow),
        .switchOn(switchOn[i]),
        .statusBit(statusBits[i])
      );
    end
  endgenerate
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      csPrev <= 1'b1;
      ovSticky <= 1'b0;
      shifter <= {WIDTH{1'b0}};
      serialOut <= 1'b0;
      serialOutEnable <= 1'b0;
      commandWord <= `OSWFS_ALL_OFF;
    end
    else
    begin
      csPrev <= chipSelect_n;
      // sticky until the next frame reports it, set wins over clear
      if (loadSupplyOverVoltage)
        ovSticky <= 1'b1;
      else if (csFall)
        ovSticky <= 1'b0;
      if (csFall)
      begin
        // status snapshot: result of the previous command
        shifter <= (ovSticky | loadSupplyOverVoltage) ? `OSWFS_ALL_OFF : statusBits;
        serialOut <= (ovSticky | loadSupplyOverVoltage) ? 1'b1 : statusBits[WIDTH-1];
        serialOutEnable <= 1'b1;
      end
      else if (!chipSelect_n && shiftStrobe)
      begin
        // msb first both ways
        shifter <= {shifter[WIDTH-2:0], serialIn};
        serialOut <= shifter[WIDTH-2];
      end
      else if (csRise)
      begin
        serialOutEnable <= 1'b0;
        if (!loadSupplyOverVoltage)
          commandWord <= shifter;
      end
    end
  end
endmodule

// [sim/oswfs_props.sv]
// assertions on the fault logic ports
`timescale 1ns/1ps
module oswfs_props(
  input wire clk_sys,
  input wire reset_n,
  input wire chipSelect_n,
  input wire serialOut,
  input wire serialOutEnable,
  input wire loadSupplyOverVoltage,
  input wire [7:0] overTemp,
  input wire [7:0] switchOn,
  input wire [7:0] commandWord
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_ov_off: assert property (loadSupplyOverVoltage |-> !switchOn) else $error("ov on");
  a_hot_off: assert property (!(overTemp & switchOn)) else $error("hot on");
  a_cmd_gate: assert property (!(commandWord & switchOn)) else $error("off on");
  a_fall_en: assert property ($fell(chipSelect_n) |=> serialOutEnable) else $error("no en");
  a_idle_off: assert property (chipSelect_n && $past(chipSelect_n) |-> !serialOutEnable) else $error("en");
  a_cmd_rise: assert property ($changed(commandWord) |-> $past(chipSelect_n) && !$past(chipSelect_n, 2))
    else $error("cw moved");
  a_ov_keep: assert property (loadSupplyOverVoltage && $rose(chipSelect_n) |=> $stable(commandWord))
    else $error("ov cw");
  a_ov_ff: assert property (loadSupplyOverVoltage && $fell(chipSelect_n) |=> serialOut)
    else $error("not ff");
endmodule
bind oswfs_fault_logic oswfs_props u_props(.*);

// [sim/oswfs_host.sv]
// host model sending command frames
`timescale 1ns/1ps
module oswfs_host(
  input wire clk_sys,
  input wire serialOut,
  output reg chipSelect_n = 1'h1,
  output reg shiftStrobe = 1'h0,
  output reg serialIn = 1'h0
);
  // status read at negedge, clear of edge updates
  task xfer(input [7:0] c, output [7:0] s);
    @(posedge clk_sys) chipSelect_n <= 1'h0;
    repeat (2) @(posedge clk_sys);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge clk_sys) s[i] = serialOut;
      @(posedge clk_sys) shiftStrobe <= 1'h1;
      serialIn <= c[i];
      @(posedge clk_sys) shiftStrobe <= 1'h0;
      serialIn <= !c[i];
      @(posedge clk_sys);
    end
    chipSelect_n <= 1'h1;
  endtask
endmodule

// [sim/testbench.sv]
// bench for the octal switch fault logic
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; $display("BAD %0t mismatch", $time); end end
module testbench;
  reg clk_sys = 1'h0;
  reg reset_n = 1'h0;
  reg ovr = 1'h0;
  reg spd = 1'h1;
  reg [7:0] hot = 8'h00;
  reg [7:0] drn = 8'hFF;
  reg [7:0] c, s, p;
  wire chipSelect_n, shiftStrobe, serialIn, serialOut, serialOutEnable;
  wire [7:0] sw, commandWord;
  integer n_errors = 0, total_checks = 0, cyc = 0, k;
  always #10 clk_sys = ~clk_sys;
  oswfs_host i_host(.*);
  oswfs_fault_logic #(.OPEN_DELAY_US(1), .SHORT_DELAY_US(1)) i_dut(.*, .overTemp(hot),
    .loadSupplyOverVoltage(ovr), .drainThreshold(drn), .shortProtectDisable(spd), .switchOn(sw));
  task w(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  task final_report;
    $display("%0d checks %0d errors", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      final_report;
    end
  end
  // status is the previous command with fault bits flipped
  task xf(input [7:0] v, input [7:0] f);
    i_host.xfer(v, s);
    `CHK(s, p ^ f)
    p = v;
    @(posedge clk_sys) drn <= v;
    w(150);
  endtask
  initial
  begin
    k = $urandom(32'h5684);
    w(16);
    reset_n <= 1'h1;
    p = 8'hFF;
    w(2);
    `CHK(({commandWord, sw}), 16'hFF00)
    for (k = 0; k < 6; k++)
    begin
      if (!k[0])
        c = $urandom;
      xf(c, 8'h00);
      `CHK(sw, ~c)
      `CHK(commandWord, c)
    end
    xf(8'h00, 8'h00);
    hot <= 8'h04;
    drn <= 8'h04;
    w(2);
    `CHK(sw, 8'hFB)
    hot <= 8'h00;
    w(2);
    `CHK(sw, 8'hFB)
    xf(8'h00, 8'h04);
    xf(8'h80, 8'h00);
    drn <= 8'h00;
    w(100);
    xf(8'h80, 8'h80);
    drn <= 8'h00;
    i_host.xfer(8'h80, s);
    `CHK(s, 8'h00)
    i_host.xfer(8'h80, s);
    `CHK(s, 8'h80)
    drn <= 8'h80;
    xf(8'h00, 8'h00);
    drn <= 8'h01;
    w(100);
    `CHK(sw, 8'hFF)
    xf(8'h00, 8'h01);
    spd <= 1'h0;
    drn <= 8'h01;
    w(100);
    `CHK(sw, 8'hFE)
    xf(8'h00, 8'h01);
    spd <= 1'h1;
    ovr <= 1'h1;
    w(2);
    `CHK(sw, 8'h00)
    xf(8'h00, 8'hFF);
    ovr <= 1'h0;
    xf(8'h00, 8'hFF);
    xf(8'h00, 8'h00);
    final_report;
  end
endmodule
